/* File: verilog/hcs_pkg.sv */
/*
 * Constants for the harvester configuration-select block: bus addresses,
 * register offsets, field layouts, reset values and timing counts.
 * Assumes a 25 MHz core clock.
 */
`default_nettype none
package hcs_pkg;
   // ----------------------------------------------------------------------
   // Bus addresses and register offsets
   // ----------------------------------------------------------------------
   localparam logic [6:0] ADDR_STRAP_HIGH   = 7'h41;
   localparam logic [6:0] ADDR_STRAP_LOW    = 7'h40;
   localparam logic [7:0] OFS_TRACK_CFG     = 8'h01;
   localparam logic [7:0] OFS_TEMP_COLD     = 8'h04;
   localparam logic [7:0] OFS_TEMP_HOT      = 8'h05;
   localparam logic [7:0] OFS_LOAD_CTRL     = 8'h0b;
   localparam logic [7:0] OFS_STATUS        = 8'h0d;

   // ----------------------------------------------------------------------
   // Field layouts and reset values
   // ----------------------------------------------------------------------
   localparam int         RATIO_LSB         = 0;
   localparam int         TIMING_LSB        = 4;
   localparam int         LOAD_BIT          = 0;
   localparam int         BUSY_BIT          = 2;
   localparam int         STAT_TEMP_BIT     = 4;
   localparam int         STAT_CHARGE_BIT   = 6;
   localparam logic [7:0] TRACK_CFG_RESET   = 8'h77;
   localparam logic [7:0] TEMP_COLD_RESET   = 8'h8f;
   localparam logic [7:0] TEMP_HOT_RESET    = 8'h2f;
   localparam logic [3:0] RATIO_STRAP_LOW   = 4'h5;
   localparam logic [3:0] RATIO_STRAP_HIGH  = 4'h7;
   localparam logic [2:0] TIMING_64MS_4S    = 3'h2;

   // ----------------------------------------------------------------------
   // Timing: clock rate and the 64 ms / 4 s tracking window
   // ----------------------------------------------------------------------
   localparam longint     CLK_HZ            = 25000000;
   localparam longint     SAMPLE_MS         = 64;
   localparam longint     PERIOD_S          = 4;
   localparam longint     SAMPLE_CYC        = (CLK_HZ * SAMPLE_MS) / 1000;
   localparam longint     PERIOD_CYC        = CLK_HZ * PERIOD_S;
endpackage : hcs_pkg
`default_nettype wire

/* File: verilog/hcs_track_timer.sv */
/*
 * Tracking timer: repeats an evaluation window of a given length within
 * a given period. Assumes the lengths are stable while enabled.
 */
`timescale 1ns/100ps
`default_nettype none
module hcs_track_timer #(
   parameter int CNT_W = 32
) (
   input  wire logic             core_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             enable_in,
   input  wire logic [CNT_W-1:0] sample_cyc_in,
   input  wire logic [CNT_W-1:0] period_cyc_in,
   output var  logic             sampling_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             samp_q;
   logic             samp_d;

   // Counts through one period; the window is its first part.
   // The window is judged on the present count, so the first window
   // after enable is as long as every later one.
   always_comb
   begin
      cnt_d  = '0;
      samp_d = 1'b0;
      if (enable_in)
      begin
         if (cnt_q >= period_cyc_in - 1'b1)
            cnt_d = '0;
         else
            cnt_d = cnt_q + 1'b1;
         samp_d = (cnt_q < sample_cyc_in);
      end
   end

   // Registers the counter and window flag.
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cnt_q  <= '0;
         samp_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         samp_q <= samp_d;
      end
   end

   assign sampling_out = samp_q;
endmodule : hcs_track_timer
`default_nettype wire

/* File: verilog/hcs_config_select.sv */
/*
 * Configuration-select register bank. Straps choose the configuration
 * after reset; a load command switches to the register values.
 * Assumes a register port already decoded from the serial bus, and
 * strap and temperature inputs synchronous to core_clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
module hcs_config_select #(
   parameter longint SAMPLE_CYC = hcs_pkg::SAMPLE_CYC,
   parameter longint PERIOD_CYC = hcs_pkg::PERIOD_CYC
) (
   input  wire logic       core_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       addr_strap_in,
   input  wire logic       charge_inhibit_strap_in,
   input  wire logic       thermal_select_input_in,
   input  wire logic       tracking_ratio_strap_in,
   input  wire logic [7:0] temperature_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   output var  logic [7:0] reg_rdata_out,
   output var  logic [6:0] bus_addr_out,
   output var  logic       charge_enable_out,
   output var  logic       temp_fault_out,
   output var  logic       reg_config_active_out,
   output var  logic [3:0] tracking_ratio_out,
   output var  logic       tracking_sample_out
);
   // ----------------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------------
   // The timer counts in 32 bits and needs a window shorter than its period.
   if (SAMPLE_CYC < 1 || PERIOD_CYC <= SAMPLE_CYC || PERIOD_CYC >= 64'h1_0000_0000)
   begin : g_bad_counts
      $error("hcs_config_select: bad tracking counts");
   end

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   logic [7:0] track_cfg_q, track_cfg_d;
   logic [7:0] cold_q,      cold_d;
   logic [7:0] hot_q,       hot_d;
   logic       active_q,    active_d;
   logic       captured_q,  captured_d;
   logic [6:0] addr_q,      addr_d;
   logic [7:0] rdata_q,     rdata_d;
   logic       chg_q,       chg_d;
   logic       tfault_q,    tfault_d;
   logic [3:0] ratio_q,     ratio_d;
   logic       samp_en;
   logic       samp_raw;
   logic       samp_q;

   // Timing field to window length in cycles; the period is fixed at PERIOD_CYC.
   function automatic logic [31:0] window_cyc(input logic [2:0] timing);
      window_cyc = (timing == hcs_pkg::TIMING_64MS_4S) ? 32'(SAMPLE_CYC)
                                                       : 32'(SAMPLE_CYC / 32);
   endfunction : window_cyc

   // ----------------------------------------------------------------------
   // Register writes, load command and address capture
   // ----------------------------------------------------------------------
   // Decodes writes; the strap address is taken on the first edge after reset.
   always_comb
   begin
      track_cfg_d = track_cfg_q;
      cold_d      = cold_q;
      hot_d       = hot_q;
      active_d    = active_q;
      captured_d  = 1'b1;
      addr_d      = addr_q;
      if (!captured_q)
         addr_d = addr_strap_in ? hcs_pkg::ADDR_STRAP_HIGH
                                : hcs_pkg::ADDR_STRAP_LOW;
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            hcs_pkg::OFS_TRACK_CFG: track_cfg_d = reg_wdata_in;
            hcs_pkg::OFS_TEMP_COLD: cold_d      = reg_wdata_in;
            hcs_pkg::OFS_TEMP_HOT:  hot_d       = reg_wdata_in;
            hcs_pkg::OFS_LOAD_CTRL:
               if (reg_wdata_in[hcs_pkg::LOAD_BIT])
                  active_d = 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Effective configuration: straps until loaded, registers after
   // ----------------------------------------------------------------------
   // Straps rule until a load; after it the register defaults apply, so
   // monitoring stays on and the strap inhibit no longer counts.
   always_comb
   begin
      logic inhibit;
      logic mon_en;
      inhibit = 1'b0;
      mon_en  = 1'b0;
      if (active_q)
      begin
         inhibit = 1'b0;
         mon_en  = 1'b1;
         ratio_d = track_cfg_q[hcs_pkg::RATIO_LSB +: 4];
      end
      else
      begin
         inhibit = charge_inhibit_strap_in;
         mon_en  = thermal_select_input_in;
         ratio_d = tracking_ratio_strap_in ? hcs_pkg::RATIO_STRAP_HIGH
                                           : hcs_pkg::RATIO_STRAP_LOW;
      end
      // Cold threshold is the larger code (thermistor falls with heat).
      tfault_d = mon_en && (temperature_in > cold_q || temperature_in < hot_q);
      chg_d    = !inhibit && !tfault_d;
   end

   // ----------------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------------
   // Read mux; unmapped offsets read as zero.
   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            hcs_pkg::OFS_TRACK_CFG: rdata_d = track_cfg_q;
            hcs_pkg::OFS_TEMP_COLD: rdata_d = cold_q;
            hcs_pkg::OFS_TEMP_HOT:  rdata_d = hot_q;
            hcs_pkg::OFS_LOAD_CTRL: rdata_d = {7'h00, active_q};
            hcs_pkg::OFS_STATUS:
            begin
               rdata_d = 8'h00;
               rdata_d[hcs_pkg::STAT_TEMP_BIT]   = tfault_q;
               rdata_d[hcs_pkg::STAT_CHARGE_BIT] = chg_q;
            end
            default:                rdata_d = 8'h00;
         endcase
      end
   end

   // The window timer runs only once the register configuration is active.
   assign samp_en = active_q;

   // ----------------------------------------------------------------------
   // Tracking window and state registers
   // ----------------------------------------------------------------------
   // Tracking window timer for the loaded configuration.
   hcs_track_timer #(
      .CNT_W (32)
   ) u_timer (
      .core_clk_in   (core_clk_in),
      .rst_b_in      (rst_b_in),
      .enable_in     (samp_en),
      .sample_cyc_in (window_cyc(track_cfg_q[hcs_pkg::TIMING_LSB +: 3])),
      .period_cyc_in (32'(PERIOD_CYC)),
      .sampling_out  (samp_raw)
   );

   // Registers all state; unwritten registers keep defaults.
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         track_cfg_q <= hcs_pkg::TRACK_CFG_RESET;
         cold_q      <= hcs_pkg::TEMP_COLD_RESET;
         hot_q       <= hcs_pkg::TEMP_HOT_RESET;
         active_q    <= 1'b0;
         captured_q  <= 1'b0;
         addr_q      <= hcs_pkg::ADDR_STRAP_HIGH;
         rdata_q     <= 8'h00;
         chg_q       <= 1'b0;
         tfault_q    <= 1'b0;
         ratio_q     <= 4'h0;
         samp_q      <= 1'b0;
      end
      else
      begin
         track_cfg_q <= track_cfg_d;
         cold_q      <= cold_d;
         hot_q       <= hot_d;
         active_q    <= active_d;
         captured_q  <= captured_d;
         addr_q      <= addr_d;
         rdata_q     <= rdata_d;
         chg_q       <= chg_d;
         tfault_q    <= tfault_d;
         ratio_q     <= ratio_d;
         samp_q      <= samp_raw;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Every output comes straight from a flip-flop.
   assign reg_rdata_out         = rdata_q;
   assign bus_addr_out          = addr_q;
   assign charge_enable_out     = chg_q;
   assign temp_fault_out        = tfault_q;
   assign reg_config_active_out = active_q;
   assign tracking_ratio_out    = ratio_q;
   assign tracking_sample_out   = samp_q;
endmodule : hcs_config_select
`default_nettype wire

/* File: tb/hcs_config_checker.sv */
/* Port checker for the configuration-select block.
   Assumes it is bound to hcs_config_select and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module hcs_config_checker (
   input wire logic       core_clk_in,
   input wire logic       rst_b_in,
   input wire logic       addr_strap_in,
   input wire logic       charge_inhibit_strap_in,
   input wire logic       thermal_select_input_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [6:0] bus_addr_out,
   input wire logic       charge_enable_out,
   input wire logic       temp_fault_out,
   input wire logic       reg_config_active_out,
   input wire logic [3:0] tracking_ratio_out,
   input wire logic       tracking_sample_out
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   // A load command is a write of bit 0 to the control offset.
   wire logic load_req = reg_wr_in && reg_addr_in == hcs_pkg::OFS_LOAD_CTRL && reg_wdata_in[0];
   sequence s_win_rise;
      $rose(tracking_sample_out) && tracking_ratio_out == 4'h3;
   endsequence
   chk_addr_capture: assert property (
      $rose(rst_b_in) |=> bus_addr_out == ($past(addr_strap_in) ? 7'h41 : 7'h40))
      else $error("Bus address does not follow the strap.");
   chk_addr_hold: assert property (
      $past(rst_b_in, 2) |-> $stable(bus_addr_out)) else $error("Bus address moved.");
   chk_inhibit_strap: assert property (
      (charge_inhibit_strap_in && !reg_config_active_out) [*3] |-> !charge_enable_out)
      else $error("Charging while inhibited.");
   chk_fault_blocks: assert property (
      temp_fault_out [*2] |-> !charge_enable_out) else $error("Charging out of window.");
   chk_monitor_off: assert property (
      (!thermal_select_input_in && !reg_config_active_out) [*3] |-> !temp_fault_out)
      else $error("Fault while monitoring is off.");
   chk_load_cmd: assert property (
      load_req |=> reg_config_active_out) else $error("Load command not taken.");
   chk_load_origin: assert property (
      $rose(reg_config_active_out) |-> $past(load_req)) else $error("Load without command.");
   chk_load_sticky: assert property (
      reg_config_active_out |=> reg_config_active_out) else $error("Load undone.");
   chk_win_len: assert property (
      s_win_rise |-> tracking_sample_out [*8] ##1 !tracking_sample_out)
      else $error("Evaluation window length wrong.");
   chk_win_period: assert property (
      s_win_rise |-> ##64 $rose(tracking_sample_out)) else $error("Evaluation period wrong.");
endmodule : hcs_config_checker
`default_nettype wire

/* File: tb/hcs_host_model.sv */
/* Host model: issues single register writes and reads.
   Assumes requests are taken on the rising edge of clk_in. */
`timescale 1ns/100ps
`default_nettype none
module hcs_host_model (
   input  wire logic       clk_in,
   output var  logic       wr_out = 1'b0,
   output var  logic       rd_out = 1'b0,
   output var  logic [7:0] addr_out = 8'h00,
   output var  logic [7:0] data_out = 8'h00
);
   // One request held for one edge; a released bus shows the inverse value.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_out   <= w;
      rd_out   <= !w;
      addr_out <= a;
      data_out <= d;
      @(posedge clk_in);
      wr_out   <= 1'b0;
      rd_out   <= 1'b0;
      addr_out <= ~a;
      data_out <= ~d;
   endtask : xfer
endmodule : hcs_host_model
`default_nettype wire

/* File: tb/testbench.sv */
/* Testbench for the configuration-select block.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, a_strap = 1'b0, inh = 1'b1, th = 1'b1, r_strap = 1'b1;
   logic [7:0] temp = 8'h60, rdata;
   logic [7:0] exp_q[$];
   logic [6:0] bus;
   logic [3:0] ratio;
   logic       chg, fault, act, smp, rd_pend = 1'b0;
   wire logic  h_wr, h_rd;
   wire logic [7:0] h_addr, h_data;
   int mismatches = 0, n_checks = 0, seed = 32'h4407, k, h;
   // Free-running 25 MHz clock.
   always #20 clk = ~clk;
   hcs_host_model u_host (.clk_in(clk), .wr_out(h_wr), .rd_out(h_rd), .addr_out(h_addr),
      .data_out(h_data));
   hcs_config_select #(.SAMPLE_CYC(8), .PERIOD_CYC(64)) u_dut (.core_clk_in(clk),
      .rst_b_in(rst_b), .addr_strap_in(a_strap), .charge_inhibit_strap_in(inh),
      .thermal_select_input_in(th), .tracking_ratio_strap_in(r_strap), .temperature_in(temp),
      .reg_wr_in(h_wr), .reg_rd_in(h_rd), .reg_addr_in(h_addr), .reg_wdata_in(h_data),
      .reg_rdata_out(rdata), .bus_addr_out(bus), .charge_enable_out(chg),
      .temp_fault_out(fault), .reg_config_active_out(act), .tracking_ratio_out(ratio),
      .tracking_sample_out(smp));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d.", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask : settle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.xfer(1'b0, a, 8'h00);
   endtask : rd
   task automatic do_reset(input logic s);
      a_strap <= s;
      rst_b   <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      settle;
   endtask : do_reset
   // Read data is compared one cycle after the strobe is taken.
   always @(posedge clk)
   begin
      if (rd_pend)
         check(rdata, exp_q.pop_front());
      rd_pend <= h_rd;
   end
   // Main sequence.
   initial
   begin
      do_reset(1'b0);
      check(8'(bus), 8'h40);
      a_strap <= 1'b1;
      settle;
      check(8'(bus), 8'h40);
      do_reset(1'b1);
      check(8'(bus), 8'h41);
      check(8'(chg), 8'h00);
      check(8'(ratio), 8'h07);
      $display("Address test done.");
      inh  <= 1'b0;
      temp <= 8'h90;
      settle;
      check(8'({fault, chg}), 8'h02);
      th      <= 1'b0;
      r_strap <= 1'b0;
      settle;
      check(8'({fault, chg}), 8'h01);
      check(8'(ratio), 8'h05);
      th   <= 1'b1;
      temp <= 8'h20;
      settle;
      check(8'({fault, chg}), 8'h02);
      rd(8'h01, 8'h77);
      rd(8'h33, 8'h00);
      $display("Strap test done.");
      u_host.xfer(1'b1, 8'h01, 8'h23);
      u_host.xfer(1'b1, 8'h04, 8'ha0);
      u_host.xfer(1'b1, 8'h0b, 8'h00);
      settle;
      check(8'(act), 8'h00);
      u_host.xfer(1'b1, 8'h0b, 8'h01);
      inh  <= 1'b1;
      th   <= 1'b0;
      temp <= 8'h95;
      settle;
      check(8'(act), 8'h01);
      check(8'(ratio), 8'h03);
      check(8'({fault, chg}), 8'h01);
      temp <= 8'ha8;
      settle;
      check(8'({fault, chg}), 8'h02);
      temp <= 8'h30 + 8'($random(seed) & 32'h3f);
      settle;
      rd(8'h0d, 8'h40);
      rd(8'h01, 8'h23);
      rd(8'h04, 8'ha0);
      rd(8'h05, 8'h2f);
      rd(8'h0b, 8'h01);
      k = 0;
      while (smp !== 1'b1 && k < 200)
      begin
         @(posedge clk);
         k++;
      end
      for (k = 0; smp === 1'b1 && k < 200; k++)
         @(posedge clk);
      h = k;
      for (; smp !== 1'b1 && k < 200; k++)
         @(posedge clk);
      check(8'(h), 8'h08);
      check(8'(k), 8'h40);
      $display("Load test done.");
      tally_and_finish;
   end
   // Watchdog well beyond the expected run of about 190 cycles.
   initial
   begin
      #200000;
      mismatches++;
      tally_and_finish;
   end
endmodule : testbench
bind hcs_config_select hcs_config_checker u_chk (.core_clk_in(core_clk_in),
   .rst_b_in(rst_b_in), .addr_strap_in(addr_strap_in),
   .charge_inhibit_strap_in(charge_inhibit_strap_in),
   .thermal_select_input_in(thermal_select_input_in), .reg_wr_in(reg_wr_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .bus_addr_out(bus_addr_out),
   .charge_enable_out(charge_enable_out), .temp_fault_out(temp_fault_out),
   .reg_config_active_out(reg_config_active_out), .tracking_ratio_out(tracking_ratio_out),
   .tracking_sample_out(tracking_sample_out));
`default_nettype wire
